// ==== rmlu_pkg.sv ====
// Constants, types and decoding helpers shared by the register move and load unit.
package rmlu_pkg;

	// ----------------------------------------------------------------
	// Opcode fields, instruction word left aligned in 32 bits.
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_XA_LOAD   = 8'hed;      // Top byte, extended register load.
	localparam logic [3:0] OPC_XA_TAIL   = 4'hf;       // Low nibble of the third byte.
	localparam logic [7:0] OPC_IMM_BYTE  = 8'he6;      // Top byte, short immediate store.
	localparam logic [7:0] OPC_IMM_WORD  = 8'hfb;      // Top byte, long immediate store.
	localparam logic [6:0] OPC_ACC_TO_TA = 7'h22;      // 0100 010, HI(acc) or CPU reg to Addr_or_temp_reg.
	localparam logic [6:0] OPC_MOVE      = 7'h11;      // 0010 001, general register move.
	localparam logic [6:0] OPC_TA_TO_ACC = 7'h29;      // 0101 001, Addr_or_temp_reg to HI(acc) or CPU reg.

	// Destination selector nibble, Addr_or_temp_reg to CPU register.
	localparam logic [3:0] WR_BLOCK_REPEAT_COUNT_0 = 4'he;
	localparam logic [3:0] WR_BLOCK_REPEAT_COUNT_1 = 4'hd;
	localparam logic [3:0] WR_CDP  = 4'ha;
	localparam logic [3:0] WR_CSR  = 4'hc;
	localparam logic [3:0] WR_SP   = 4'h8;
	localparam logic [3:0] WR_SSP  = 4'h9;
	// Source selector nibble, CPU register to Addr_or_temp_reg.
	localparam logic [3:0] RD_BLOCK_REPEAT_COUNT_0 = 4'hc;
	localparam logic [3:0] RD_BLOCK_REPEAT_COUNT_1 = 4'hd;
	localparam logic [3:0] RD_CDP  = 4'ha;
	localparam logic [3:0] RD_SP   = 4'h8;
	localparam logic [3:0] RD_SSP  = 4'h9;
	localparam logic [3:0] RD_SINGLE_REPEAT_COUNTER = 4'he;

	// ----------------------------------------------------------------
	// Datapath constants.
	// ----------------------------------------------------------------
	localparam logic [39:0] SAT_POS       = 40'h007fffffff;
	localparam logic [39:0] SAT_NEG       = 40'hff80000000;
	localparam logic [1:0]  SETTLE_CYCLES = 2'h3;     // Cycles before a new pointer may be used.

	// ----------------------------------------------------------------
	// APB register map, byte addresses, and field positions.
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_FLAGS    = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_CLR  = 8'h0c;
	localparam logic [7:0] ADDR_INT_EN   = 8'h10;
	localparam int         INT_OVF       = 0;
	localparam int         INT_REJ       = 1;
	localparam logic [3:0] CTRL_RESET    = 4'h0;

	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_XA_LOAD   = 3'b001,
		OP_IMM_BYTE  = 3'b010,
		OP_IMM_WORD  = 3'b011,
		OP_HI_TO_TA  = 3'b100,
		OP_CPU_TO_TA = 3'b101,
		OP_MOVE      = 3'b110,
		OP_TA_TO_HI  = 3'b111
	} rmlu_op_t;

	// Mode bits; all but legacy_compat_mode steer the accumulator datapath.
	typedef struct packed {
		logic legacy_compat_mode;
		logic sign_extend_mode;
		logic dunit_saturate_mode;
		logic guard_bit_overflow_mode;
	} rmlu_mode_t;

	typedef struct packed {
		logic [15:0] block_repeat_count_0;
		logic [15:0] block_repeat_count_1;
		logic [15:0] block_repeat_save_1;
		logic [15:0] coeff_data_pointer;
		logic [15:0] computed_repeat_count;
		logic [15:0] data_stack_pointer;
		logic [15:0] system_stack_pointer;
	} rmlu_cpu_regs_t;

	// Register codes 0..3 name the accumulators, the rest the Addr_or_temp_reg registers.
	function automatic logic rmlu_is_acc(input logic [3:0] code);
		return code[3:2] == 2'b00;
	endfunction

	function automatic logic [39:0] rmlu_ext40(input logic [15:0] v, input logic sx);
		return {{24{sx & v[15]}}, v};
	endfunction

endpackage

// ==== rmlu_top.sv ====
// Decode and execute logic for register move, extended load and immediate store instructions.
`timescale 1ns/1ps

// Summary of operation
// - Extended register load keeps only the low 23 bits of the long operand.
// - Upper 7 bits from first word low bits, lower 16 from next word.
// - Immediate store writes a signed byte or word constant to memory.
// - The byte constant is always sign-extended to 16 bits before the store.
// - Accumulator bits 31..16 move into a Addr_or_temp_reg register as a 16-bit operation.
// - Moves into an accumulator are 40-bit with overflow checked per guard-bit mode.
// - On overflow set the accumulator overflow flag; saturate when saturation mode is on.
// - A Addr_or_temp_reg source into an accumulator is extended to 40 bits per sign mode.
// - Moves into Addr_or_temp_reg are 16-bit and take the accumulator's low 16 bits.
// - Addr_or_temp_reg into accumulator bits 31..16 uses the same overflow and saturation handling.
// - Addr_or_temp_reg to CPU register destination decoded from the low opcode nibble.
// - Addr_or_temp_reg and CPU register transfers run in the execute phase through the ALU.
// - Pointer, counter or Addr_or_temp_reg updates are flagged unusable for three cycles.
// - Writing block repeat count 1 also writes the block repeat save register.
// - CPU register to Addr_or_temp_reg source decoded from the opcode selector field.
// - Repeated reads of the single repeat counter are rejected.
module rmlu_top
	import rmlu_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr_word,
	input  wire logic        instr_repeat,
	input  wire logic [15:0] mem_word_hi,
	input  wire logic [15:0] mem_word_lo,
	input  wire logic [15:0] single_repeat_counter,
	input  wire logic        rf_wr_en,
	input  wire logic [3:0]  rf_wr_sel,
	input  wire logic [39:0] rf_wr_data,
	input  wire logic [3:0]  rf_rd_sel,
	input  wire logic [2:0]  xar_rd_sel,
	output logic      [39:0] rf_rd_data,
	output logic      [22:0] xar_rd_data,
	output logic             mem_wr_en,
	output logic      [15:0] mem_wr_data,
	output logic             move_done,
	output logic             move_reject,
	output logic      [3:0]  acc_overflow_flag,
	output rmlu_cpu_regs_t   cpu_regs,
	output logic             ptr_settle_pending,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Architectural state.
	// ----------------------------------------------------------------
	logic [39:0] acc [4];
	logic [15:0] addr_or_temp_reg [16];
	logic [22:0] ext_addr_dest_reg [8];
	rmlu_mode_t  mode;
	logic [1:0]  settle_cnt;
	logic [1:0]  int_stat;
	logic [1:0]  int_en;

	// ----------------------------------------------------------------
	// Instruction decode.
	// ----------------------------------------------------------------
	function automatic rmlu_op_t rmlu_classify(input logic [31:0] w);
		rmlu_op_t r;
		r = OP_NONE;
		if (w[31:24] == OPC_XA_LOAD && w[11:8] == OPC_XA_TAIL) begin
			r = OP_XA_LOAD;
		end else if (w[31:24] == OPC_IMM_BYTE) begin
			r = OP_IMM_BYTE;
		end else if (w[31:24] == OPC_IMM_WORD) begin
			r = OP_IMM_WORD;
		end else if (w[31:25] == OPC_ACC_TO_TA) begin
			r = w[23] ? OP_CPU_TO_TA : (w[22] ? OP_NONE : OP_HI_TO_TA);
		end else if (w[31:25] == OPC_MOVE) begin
			r = OP_MOVE;
		end else if (w[31:25] == OPC_TA_TO_ACC && w[19:18] == 2'b00) begin
			r = OP_TA_TO_HI;
		end else if (w[31:25] == OPC_TA_TO_ACC) begin
			// The Addr_or_temp_reg to CPU register form has its own strobe, ta_to_cpu, below.
			r = OP_NONE;
		end
		return r;
	endfunction

	// A Addr_or_temp_reg to CPU register transfer shares the TA_TO_ACC prefix; it is recognised separately.
	wire         ta_to_cpu = instr_valid && instr_word[31:25] == OPC_TA_TO_ACC
		&& instr_word[19:18] != 2'b00;
	wire rmlu_op_t op      = instr_valid ? rmlu_classify(instr_word) : OP_NONE;
	wire [3:0]   src_code  = instr_word[23:20];
	wire [3:0]   dst_code  = instr_word[19:16];
	wire [3:0]   cpu_wsel  = instr_word[19:16];
	wire [15:0]  ta_src    = addr_or_temp_reg[src_code];

	// ----------------------------------------------------------------
	// CPU register read selection and rejection of repeated counter reads.
	// ----------------------------------------------------------------
	wire [15:0] cpu_rd =
		(src_code == RD_BLOCK_REPEAT_COUNT_0) ? cpu_regs.block_repeat_count_0 :
		(src_code == RD_BLOCK_REPEAT_COUNT_1) ? cpu_regs.block_repeat_count_1 :
		(src_code == RD_CDP)  ? cpu_regs.coeff_data_pointer :
		(src_code == RD_SP)   ? cpu_regs.data_stack_pointer :
		(src_code == RD_SSP)  ? cpu_regs.system_stack_pointer :
		single_repeat_counter;
	wire cpu_rd_ok = src_code == RD_BLOCK_REPEAT_COUNT_0 || src_code == RD_BLOCK_REPEAT_COUNT_1 || src_code == RD_CDP
		|| src_code == RD_SP || src_code == RD_SSP || src_code == RD_SINGLE_REPEAT_COUNTER;
	// The counter is live during a single repeat, so reading it then has no defined value.
	wire reject    = op == OP_CPU_TO_TA && src_code == RD_SINGLE_REPEAT_COUNTER && instr_repeat;
	wire cpu_wr_ok = cpu_wsel == WR_BLOCK_REPEAT_COUNT_0 || cpu_wsel == WR_BLOCK_REPEAT_COUNT_1 || cpu_wsel == WR_CDP
		|| cpu_wsel == WR_CSR || cpu_wsel == WR_SP || cpu_wsel == WR_SSP;
	wire cpu_we    = ta_to_cpu && cpu_wr_ok;

	// ----------------------------------------------------------------
	// Accumulator datapath: extension, overflow and saturation.
	// ----------------------------------------------------------------
	wire [1:0]  hi_acc   = instr_word[17:16];
	wire [39:0] hi_raw   = {{8{mode.sign_extend_mode & ta_src[15]}}, ta_src,
		acc[hi_acc][15:0]};
	wire [39:0] mv_raw   = rmlu_is_acc(src_code) ? acc[src_code[1:0]]
		: rmlu_ext40(ta_src, mode.sign_extend_mode);
	wire [39:0] acc_raw  = (op == OP_TA_TO_HI) ? hi_raw : mv_raw;
	wire [1:0]  acc_dst  = (op == OP_TA_TO_HI) ? hi_acc : dst_code[1:0];
	wire        acc_we   = (op == OP_MOVE && rmlu_is_acc(dst_code)) || op == OP_TA_TO_HI;
	// Without guard bits the result must fit 32 bits: bits 39..31 all equal.
	wire        acc_ovf  = acc_we && !mode.guard_bit_overflow_mode
		&& (|acc_raw[39:31]) && !(&acc_raw[39:31]);
	wire [39:0] acc_res  = (acc_ovf && mode.dunit_saturate_mode)
		? (acc_raw[39] ? SAT_NEG : SAT_POS) : acc_raw;

	// ----------------------------------------------------------------
	// Addr_or_temp_reg datapath, extended load and immediate store values.
	// ----------------------------------------------------------------
	wire        ta_we  = (op == OP_MOVE && !rmlu_is_acc(dst_code)) || op == OP_HI_TO_TA
		|| (op == OP_CPU_TO_TA && cpu_rd_ok && !reject);
	wire [15:0] ta_res =
		(op == OP_HI_TO_TA)  ? acc[instr_word[21:20]][31:16] :
		(op == OP_CPU_TO_TA) ? cpu_rd :
		rmlu_is_acc(src_code) ? acc[src_code[1:0]][15:0] : ta_src;
	wire [22:0] xa_res  = {mem_word_hi[6:0], mem_word_lo};
	wire [2:0]  xa_dst  = instr_word[14:12];
	wire [15:0] imm_res = (op == OP_IMM_BYTE)
		? {{8{instr_word[15]}}, instr_word[15:8]} : instr_word[15:0];
	wire        imm_we  = op == OP_IMM_BYTE || op == OP_IMM_WORD;
	wire        ptr_upd = ta_we || cpu_we;
	// A refused counter read pulses move_reject instead, so the pipeline can tell them apart.
	wire        done    = (op != OP_NONE && !reject) || ta_to_cpu;

	// Register file; a move in the same cycle as a pipeline load takes precedence.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) acc[i] <= '0;
			for (int i = 0; i < 16; i++) addr_or_temp_reg[i] <= '0;
			for (int i = 0; i < 8; i++) ext_addr_dest_reg[i] <= '0;
		end else begin
			if (rf_wr_en && rmlu_is_acc(rf_wr_sel)) acc[rf_wr_sel[1:0]] <= rf_wr_data;
			if (rf_wr_en && !rmlu_is_acc(rf_wr_sel)) addr_or_temp_reg[rf_wr_sel] <= rf_wr_data[15:0];
			if (acc_we) acc[acc_dst] <= acc_res;
			if (ta_we) addr_or_temp_reg[dst_code] <= ta_res;
			if (op == OP_XA_LOAD) ext_addr_dest_reg[xa_dst] <= xa_res;
		end
	end

	// CPU registers written from Addr_or_temp_reg in the execute phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_regs <= '0;
		end else if (cpu_we) begin
			unique case (cpu_wsel)
				WR_BLOCK_REPEAT_COUNT_0: cpu_regs.block_repeat_count_0 <= ta_src;
				WR_BLOCK_REPEAT_COUNT_1: begin
					cpu_regs.block_repeat_count_1 <= ta_src;
					cpu_regs.block_repeat_save_1 <= ta_src;
				end
				WR_CDP:  cpu_regs.coeff_data_pointer <= ta_src;
				WR_CSR:  cpu_regs.computed_repeat_count <= ta_src;
				WR_SP:   cpu_regs.data_stack_pointer <= ta_src;
				default: cpu_regs.system_stack_pointer <= ta_src;
			endcase
		end
	end

	// Settle window after a pointer update; the address stage waits on this flag.
	wire [1:0] next_settle_cnt = ptr_upd ? SETTLE_CYCLES
		: (settle_cnt != 2'h0 ? settle_cnt - 2'h1 : 2'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_cnt <= 2'h0;
			ptr_settle_pending <= 1'b0;
		end else begin
			settle_cnt <= next_settle_cnt;
			ptr_settle_pending <= next_settle_cnt != 2'h0;
		end
	end

	// Result strobes and observation ports.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wr_en <= 1'b0;
			mem_wr_data <= '0;
			move_done <= 1'b0;
			move_reject <= 1'b0;
			rf_rd_data <= '0;
			xar_rd_data <= '0;
		end else begin
			mem_wr_en <= imm_we;
			mem_wr_data <= imm_we ? imm_res : mem_wr_data;
			move_done <= done;
			move_reject <= reject;
			rf_rd_data <= rmlu_is_acc(rf_rd_sel) ? acc[rf_rd_sel[1:0]]
				: {24'h0, addr_or_temp_reg[rf_rd_sel]};
			xar_rd_data <= ext_addr_dest_reg[xar_rd_sel];
		end
	end

	// ----------------------------------------------------------------
	// APB slave: control, flags and interrupt registers.
	// ----------------------------------------------------------------
	wire       apb_setup = psel && !penable;
	wire       apb_wr    = psel && penable && pready && pwrite;
	wire       addr_hit  = paddr == ADDR_CTRL || paddr == ADDR_FLAGS || paddr == ADDR_INT_STAT
		|| paddr == ADDR_INT_CLR || paddr == ADDR_INT_EN;
	wire [3:0] flag_clr  = (apb_wr && paddr == ADDR_FLAGS) ? pwdata[3:0] : 4'h0;
	wire [1:0] int_clr   = (apb_wr && paddr == ADDR_INT_CLR) ? pwdata[1:0] : 2'h0;
	wire [3:0] ovf_set   = acc_ovf ? (4'h1 << acc_dst) : 4'h0;
	wire [1:0] int_set   = {reject, acc_ovf};
	wire [31:0] rd_mux   =
		(paddr == ADDR_CTRL)     ? {28'h0, mode} :
		(paddr == ADDR_FLAGS)    ? {28'h0, acc_overflow_flag} :
		(paddr == ADDR_INT_STAT) ? {30'h0, int_stat} :
		(paddr == ADDR_INT_EN)   ? {30'h0, int_en} : 32'h0;
	// Set wins over clear, so an event in the clearing cycle is never lost.
	wire [1:0] next_int_stat = (int_stat & ~int_clr) | int_set;

	// Bus handshake: one wait-free access phase; hardware sets beat software clears.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			mode <= CTRL_RESET;
			int_en <= 2'h0;
			int_stat <= 2'h0;
			acc_overflow_flag <= 4'h0;
			irq <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !addr_hit;
			prdata <= apb_setup && !pwrite ? rd_mux : 32'h0;
			if (apb_wr && paddr == ADDR_CTRL) mode <= pwdata[3:0];
			if (apb_wr && paddr == ADDR_INT_EN) int_en <= pwdata[1:0];
			int_stat <= next_int_stat;
			acc_overflow_flag <= (acc_overflow_flag & ~flag_clr) | ovf_set;
			irq <= |(next_int_stat & int_en);
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ptr_write;
		ptr_upd;
	endsequence
	sequence s_settle_hold;
		ptr_settle_pending [*3];
	endsequence
	sequence s_no_ptr_write;
		!ptr_upd [*3];
	endsequence

	a_xa_load_bits: assert property (op == OP_XA_LOAD |=>
		ext_addr_dest_reg[$past(xa_dst)] == {$past(mem_word_hi[6:0]), $past(mem_word_lo)})
		else $error("extended load result wrong");
	a_byte_sign_ext: assert property (op == OP_IMM_BYTE |=>
		mem_wr_en && mem_wr_data == {{8{$past(instr_word[15])}}, $past(instr_word[15:8])})
		else $error("byte immediate not sign extended");
	a_hi_to_tax: assert property (op == OP_HI_TO_TA && !rf_wr_en |=>
		addr_or_temp_reg[$past(dst_code)] == $past(acc[instr_word[21:20]][31:16]))
		else $error("high half move wrong");
	a_ovf_flag_set: assert property (acc_ovf |=> acc_overflow_flag[$past(acc_dst)]
		&& int_stat[INT_OVF]) else $error("overflow flag not set");
	a_sat_clamp: assert property (acc_ovf && mode.dunit_saturate_mode && !rf_wr_en |=>
		acc[$past(acc_dst)] == SAT_POS || acc[$past(acc_dst)] == SAT_NEG)
		else $error("saturation missing");
	a_brs_mirror: assert property (cpu_we && cpu_wsel == WR_BLOCK_REPEAT_COUNT_1 |=>
		cpu_regs.block_repeat_save_1 == cpu_regs.block_repeat_count_1)
		else $error("save register not mirrored");
	// Back to back pointer writes restart the window, so its end is checked only after quiet.
	a_settle_three: assert property (s_ptr_write |=> s_settle_hold)
		else $error("settle window not three cycles");
	a_settle_ends: assert property (s_ptr_write ##1 s_no_ptr_write
		|=> !ptr_settle_pending) else $error("settle window longer than three cycles");
	a_single_repeat_counter_reject: assert property (reject |=> move_reject && !move_done
		&& addr_or_temp_reg[$past(dst_code)] == $past(addr_or_temp_reg[dst_code]))
		else $error("repeated counter read not rejected");
	a_one_cycle: assert property (done |=> move_done ##1 !move_done || $past(done))
		else $error("move did not complete in one cycle");

	// Datapath forms that the bench reaches only once or twice.
	a_ta_sign_ext: assert property (op == OP_MOVE && rmlu_is_acc(dst_code)
		&& !rmlu_is_acc(src_code) |=> acc[$past(dst_code[1:0])]
		== {{24{$past(mode.sign_extend_mode & ta_src[15])}}, $past(ta_src)})
		else $error("register source not extended");
	a_acc_to_tax: assert property (op == OP_MOVE && !rmlu_is_acc(dst_code)
		&& rmlu_is_acc(src_code) |=> addr_or_temp_reg[$past(dst_code)]
		== $past(acc[src_code[1:0]][15:0])) else $error("accumulator low half not moved");
	a_tax_to_high: assert property (op == OP_TA_TO_HI && !acc_ovf |=>
		acc[$past(hi_acc)][31:0] == {$past(ta_src), $past(acc[hi_acc][15:0])})
		else $error("register not moved to high half");
	a_word_store: assert property (op == OP_IMM_WORD |=>
		mem_wr_en && mem_wr_data == $past(instr_word[15:0]))
		else $error("word immediate not stored");
	a_guard_quiet: assert property (acc_we && mode.guard_bit_overflow_mode
		&& flag_clr == 4'h0 |=> acc_overflow_flag == $past(acc_overflow_flag))
		else $error("overflow flagged with guard bits on");

	// CPU register transfers in both directions; writes checked for four registers, reads for two.
	a_block_repeat_count_0_write: assert property (cpu_we && cpu_wsel == WR_BLOCK_REPEAT_COUNT_0 |=>
		cpu_regs.block_repeat_count_0 == $past(ta_src))
		else $error("repeat count write wrong");
	a_cdp_write: assert property (cpu_we && cpu_wsel == WR_CDP |=>
		cpu_regs.coeff_data_pointer == $past(ta_src))
		else $error("coefficient pointer write wrong");
	a_sp_write: assert property (cpu_we && cpu_wsel == WR_SP |=>
		cpu_regs.data_stack_pointer == $past(ta_src))
		else $error("stack pointer write wrong");
	a_ssp_write: assert property (cpu_we && cpu_wsel == WR_SSP |=>
		cpu_regs.system_stack_pointer == $past(ta_src))
		else $error("system stack pointer write wrong");
	a_block_repeat_count_0_read: assert property (op == OP_CPU_TO_TA && src_code == RD_BLOCK_REPEAT_COUNT_0 |=>
		addr_or_temp_reg[$past(dst_code)] == $past(cpu_regs.block_repeat_count_0))
		else $error("repeat count read wrong");
	a_cdp_read: assert property (op == OP_CPU_TO_TA && src_code == RD_CDP |=>
		addr_or_temp_reg[$past(dst_code)] == $past(cpu_regs.coeff_data_pointer))
		else $error("coefficient pointer read wrong");

endmodule // rmlu_top

// ==== rmlu_mem_model.sv ====
// Data memory and operand fetch model that faces the move and load unit.
`timescale 1ns/1ps
module rmlu_mem_model (
	input  wire logic        pclk,
	input  wire logic        instr_valid,
	input  wire logic [15:0] op_hi,
	input  wire logic [15:0] op_lo,
	input  wire logic        mem_wr_en,
	input  wire logic [15:0] mem_wr_data,
	output logic      [15:0] mem_word_hi,
	output logic      [15:0] mem_word_lo,
	output logic      [15:0] last_store
);
	// Operands are valid only beside the instruction, so show junk otherwise.
	assign mem_word_hi = instr_valid ? op_hi : ~op_hi;
	assign mem_word_lo = instr_valid ? op_lo : ~op_lo;

	// Keep the last stored word as the memory would.
	initial last_store = 16'h0000;
	always @(posedge pclk) begin
		if (mem_wr_en === 1'b1) begin
			last_store <= mem_wr_data;
		end
	end
endmodule // rmlu_mem_model

// ==== register_move_load_unit_tb.sv ====
// Self-checking testbench for the register move and load unit.
`timescale 1ns/1ps
module register_move_load_unit_tb;
	import rmlu_pkg::*;
	typedef struct packed {
		logic [31:0] iw;
		logic [3:0]  mode;
		logic [3:0]  rs;
		logic [39:0] ex;
	} rmlu_row_t;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic           instr_valid, instr_repeat, rf_wr_en, mem_wr_en, irq;
	logic           move_done, move_reject, ptr_settle_pending;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, instr_word, rd;
	logic [15:0]    op_hi, op_lo, mem_word_hi, mem_word_lo, mem_wr_data, last_store;
	logic [15:0]    single_repeat_counter;
	logic [3:0]     rf_wr_sel, rf_rd_sel, acc_overflow_flag;
	logic [39:0]    rf_wr_data, rf_rd_data;
	logic [2:0]     xar_rd_sel;
	logic [22:0]    xar_rd_data;
	rmlu_cpu_regs_t cpu_regs;
	int             err_count, tests_run;
	logic [3:0]     wsel [6] = '{WR_BLOCK_REPEAT_COUNT_0, WR_BLOCK_REPEAT_COUNT_1, WR_CDP, WR_CSR, WR_SP, WR_SSP};
	logic [3:0]     rsel [6] = '{RD_BLOCK_REPEAT_COUNT_0, RD_BLOCK_REPEAT_COUNT_1, RD_CDP, RD_SP, RD_SSP, RD_SINGLE_REPEAT_COUNTER};
	logic [15:0]    rexp [6] = '{16'h0100, 16'h0101, 16'h0102, 16'h0104, 16'h0105, 16'h0077};
	// Ordinary moves: opcode, mode bits, register read back, expected value.
	rmlu_row_t      rows [9] = '{
		'{32'h44050000, 4'h0, 4'h5, 40'h000000e500},
		'{32'h22010000, 4'h0, 4'h1, 40'h01e5000030},
		'{32'h22020000, 4'h2, 4'h2, 40'h007fffffff},
		'{32'h22030000, 4'h1, 4'h3, 40'h01e5000030},
		'{32'h22430000, 4'h4, 4'h3, 40'hffffffe500},
		'{32'h22420000, 4'h8, 4'h2, 40'h000000e500},
		'{32'h22060000, 4'h8, 4'h6, 40'h0000000030},
		'{32'h52410000, 4'h4, 4'h1, 40'hffe5000030},
		'{32'h52400000, 4'h2, 4'h0, 40'h007fffffff}};

	rmlu_top rmlu_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .instr_valid, .instr_word, .instr_repeat, .mem_word_hi,
		.mem_word_lo, .single_repeat_counter, .rf_wr_en, .rf_wr_sel, .rf_wr_data, .rf_rd_sel,
		.xar_rd_sel, .rf_rd_data, .xar_rd_data, .mem_wr_en, .mem_wr_data, .move_done,
		.move_reject, .acc_overflow_flag, .cpu_regs, .ptr_settle_pending, .irq);
	rmlu_mem_model rmlu_mem_model_inst (.pclk, .instr_valid, .op_hi, .op_lo, .mem_wr_en,
		.mem_wr_data, .mem_word_hi, .mem_word_lo, .last_store);

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// The request is held until pready is seen high, so a slow answer still works.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Returns just after the edge that samples the instruction, while its pulses stand.
	task automatic op(input logic [31:0] iw, input logic rep);
		@(posedge pclk);
		instr_valid <= 1'b1;
		instr_word <= iw;
		instr_repeat <= rep;
		@(posedge pclk);
		instr_valid <= 1'b0;
		instr_repeat <= 1'b0;
		#1;
	endtask

	task automatic wr_rf(input logic [3:0] s, input logic [39:0] d);
		@(posedge pclk);
		rf_wr_en <= 1'b1;
		rf_wr_sel <= s;
		rf_wr_data <= d;
		@(posedge pclk);
		rf_wr_en <= 1'b0;
	endtask

	task automatic rd_rf(input logic [3:0] s, input logic [39:0] e);
		@(posedge pclk);
		rf_rd_sel <= s;
		wait_n(2);
		chk(rf_rd_data, e);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (4000) @(posedge pclk);
		err_count++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, instr_valid, instr_repeat, rf_wr_en} = '0;
		{paddr, pwdata, instr_word, rf_wr_sel, rf_wr_data, rf_rd_sel} = '0;
		{op_hi, op_lo, single_repeat_counter, xar_rd_sel} = {16'h3492, 16'h0fd3, 16'h0077, 3'd1};
		err_count = 0;
		tests_run = 0;
		wait_n(15);
		chk(cpu_regs, '0);
		chk({move_done, pready, irq}, 3'b000);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, {28'h0, CTRL_RESET});
		apb(1'b0, 8'h40, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		wr_rf(4'd0, 40'h01e5000030);
		wr_rf(4'd4, 40'h000000e500);
		$display("test reset_and_map finished");
		// Each row sets its own mode bits; only the fourth row turns the guard mode on.
		foreach (rows[i]) begin
			apb(1'b1, ADDR_CTRL, {28'h0, rows[i].mode});
			op(rows[i].iw, 1'b0);
			chk(move_done, 1'b1);
			rd_rf(rows[i].rs, rows[i].ex);
		end
		chk(acc_overflow_flag, 4'h7);
		$display("test move_rows finished");
		op(32'hed001f00, 1'b0);
		wait_n(1);
		chk(xar_rd_data, 23'h120fd3);
		op_hi <= 16'hffff;
		op(32'hed001f00, 1'b0);
		wait_n(1);
		chk(xar_rd_data, 23'h7f0fd3);
		op(32'he600f800, 1'b0);
		chk({mem_wr_en, mem_wr_data}, 17'h1fff8);
		op(32'he6007f00, 1'b0);
		chk(mem_wr_data, 16'h007f);
		op(32'hfb008001, 1'b0);
		wait_n(1);
		chk(last_store, 16'h8001);
		$display("test load_store finished");
		for (int i = 0; i < 6; i++) begin
			wr_rf(4'd7, {24'h0, 16'h0100 + 16'(i)});
			op({7'h29, 1'b0, 4'd7, wsel[i], 16'h0}, 1'b0);
			chk(ptr_settle_pending, 1'b1);
			wait_n(2);
			chk(ptr_settle_pending, 1'b1);
			wait_n(1);
			chk(ptr_settle_pending, 1'b0);
		end
		chk(cpu_regs, {16'h100, 16'h101, 16'h101, 16'h102, 16'h103, 16'h104, 16'h105});
		// No loop is running, so repeat counts are read well clear of a loop end.
		for (int i = 0; i < 6; i++) begin
			op({7'h22, 1'b0, rsel[i], 4'd8, 16'h0}, 1'b0);
			rd_rf(4'd8, {24'h0, rexp[i]});
		end
		op({7'h22, 1'b0, RD_SINGLE_REPEAT_COUNTER, 4'd9, 16'h0}, 1'b1);
		chk({move_reject, move_done}, 2'b10);
		rd_rf(4'd9, 40'h0);
		op({7'h22, 1'b0, RD_BLOCK_REPEAT_COUNT_0, 4'd9, 16'h0}, 1'b1);
		chk(move_done, 1'b1);
		rd_rf(4'd9, 40'h0100);
		$display("test cpu_transfers finished");
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chk(rd, 32'h3);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_INT_EN, 32'h2);
		wait_n(2);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_INT_CLR, 32'h2);
		wait_n(2);
		chk(irq, 1'b0);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chk(rd, 32'h1);
		$display("test interrupts finished");
		@(posedge pclk);
		presetn <= 1'b0;
		wait_n(2);
		chk({cpu_regs, acc_overflow_flag, irq}, '0);
		@(posedge pclk);
		presetn <= 1'b1;
		wait_n(2);
		chk({move_done, move_reject, mem_wr_en, ptr_settle_pending, pready}, 5'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, {28'h0, CTRL_RESET});
		op({7'h29, 1'b0, 4'd7, WR_BLOCK_REPEAT_COUNT_0, 16'h0}, 1'b0);
		chk({move_done, ptr_settle_pending, cpu_regs.block_repeat_count_0}, 18'h30000);
		$display("test mid_run_reset finished");
		complete_run();
	end
endmodule // register_move_load_unit_tb
